// file: sim/adcrc_checker.sv
`include "adcrc_consts.svh"
`default_nettype none
module adcrc_checker #(
  parameter int CONV_CLKS = 16
) (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst_b,
  input wire logic                    clkEn,
  // apb answer
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  // converter side
  input wire logic [8:0]              pinAnalogCfg,
  input wire adcrc_pkg::adcrc_analog_t anaCtrl,
  input wire logic [8:0]              pinDigitalOff,
  input wire logic [8:0]              pinPullHighOff,
  input wire logic                    convIrqReq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_pinCopy;
    $past(rst_b, 2) && $past(clkEn) |-> pinDigitalOff == $past(pinAnalogCfg);
  endproperty
  a_pinCopy: assert property (p_pinCopy) else $error("pin override lags");
  property p_pullOff;
    pinPullHighOff == pinDigitalOff;
  endproperty
  a_pullOff: assert property (p_pullOff) else $error("pull-high kept");
  property p_extOff;
    anaCtrl.srcKind != adcrc_pkg::SRC_EXT |-> !anaCtrl.extConnect;
  endproperty
  a_extOff: assert property (p_extOff) else $error("external joined");
  property p_irqPulse;
    convIrqReq |=> !convIrqReq;
  endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("irq too long");
  property p_startOnce;
    anaCtrl.sampleStart |=> !anaCtrl.sampleStart [*3];
  endproperty
  a_startOnce: assert property (p_startOnce) else $error("restart while busy");
  property p_startEn;
    anaCtrl.sampleStart |-> anaCtrl.convEnable;
  endproperty
  a_startEn: assert property (p_startEn) else $error("start while off");
  property p_done;
    anaCtrl.sampleStart |-> ##[1:100] convIrqReq;
  endproperty
  a_done: assert property (p_done) else $error("no completion");
  property p_bZero;
    pready && !pwrite && paddr == `ADCRC_OFF_CTRL_B |-> prdata[3] == 1'b0;
  endproperty
  a_bZero: assert property (p_bZero) else $error("ctrl b bit 3 set");
  property p_cZero;
    pready && !pwrite && paddr == `ADCRC_OFF_CTRL_C |-> prdata[6:5] == 2'b00;
  endproperty
  a_cZero: assert property (p_cZero) else $error("ctrl c gap set");
  property p_bgZero;
    pready && !pwrite && paddr == `ADCRC_OFF_BANDGAP |-> prdata[7:1] == 7'h00;
  endproperty
  a_bgZero: assert property (p_bgZero) else $error("bandgap gap set");
  c_start: cover property (anaCtrl.sampleStart);
  c_irq: cover property (convIrqReq);
  c_ext: cover property (anaCtrl.extConnect);
endmodule
//////////////////////////////////////////////////////////////
bind adcrc_top adcrc_checker #(.CONV_CLKS(CONV_CLKS)) u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pinAnalogCfg(pinAnalogCfg),
  .anaCtrl(anaCtrl), .pinDigitalOff(pinDigitalOff),
  .pinPullHighOff(pinPullHighOff), .convIrqReq(convIrqReq)
);
`default_nettype wire

// file: sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk = 1'b0;
  logic                     rst_b = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [11:0]              paddr = 12'h000;
  logic [31:0]              pwdata = 32'h0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     convIrqReq;
  logic [11:0]              convData = 12'h000;
  logic [8:0]               pinAnalogCfg = 9'h000;
  logic [8:0]               pinDigitalOff;
  logic [8:0]               pinPullHighOff;
  adcrc_pkg::adcrc_analog_t anaCtrl;
  logic [32:0]              expQ[$];
  logic [31:0]              rng = 32'd56;
  logic [11:0]              adr[4] = '{12'h008, 12'h00c, 12'h010, 12'h014};
  logic [7:0]               msk[4] = '{8'h00, 8'hf7, 8'h9f, 8'h01};
  int                       miscompares = 0;
  int                       samples_checked = 0;
  // short conversion keeps the run brief
  adcrc_top #(.CONV_CLKS(12)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convDone(1'b0), .convData(convData),
    .pinAnalogCfg(pinAnalogCfg), .anaCtrl(anaCtrl), .pinDigitalOff(pinDigitalOff),
    .pinPullHighOff(pinPullHighOff), .convIrqReq(convIrqReq)
  );
  //////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [32:0] route(input int i);
    if (i == 0) return {29'h0, adcrc_pkg::SRC_EXT, 1'b1};
    if (i == 4 || i > 11) return {29'h0, adcrc_pkg::SRC_FLOAT, 1'b0};
    if (i < 4) return {29'h0, adcrc_pkg::SRC_SUPPLY, 1'b0};
    if (i < 8) return {29'h0, adcrc_pkg::SRC_AMPREF, 1'b0};
    return {29'h0, adcrc_pkg::SRC_GROUND, 1'b0};
  endfunction
  task automatic results();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      results();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    rng <= xs(rng);
    pinAnalogCfg <= rng[8:0];
  end
  // answers are judged at the edge the master samples them
  always @(posedge sys_clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0)
      check("read", {pslverr, prdata}, expQ.pop_front());
  end
  initial begin
    logic [11:0] r;
    int n;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rd(adr[i], 33'h0);
    wr(12'h014, 8'h01);
    for (int i = 1; i < 4; i++) begin
      wr(adr[i], 8'hff);
      rd(adr[i], {25'h0, msk[i]});
    end
    wr(12'h008, 8'h40);
    rd(12'h008, 33'h0);
    rd(12'h018, {1'b1, 32'h0});
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      wr(12'h00c, {i[3:0], 4'h0});
      wr(12'h008, {4'h2, i[3:0]});
      repeat (2) @(posedge sys_clk);
      check("route", {29'h0, anaCtrl.srcKind, anaCtrl.extConnect}, route(i));
      if (i % 4 != 0 && i < 8) check("scale", 33'(anaCtrl.srcDivLog2), 33'(i % 4 - 1));
    end
    $display("test routing done");
    wr(12'h00c, 8'h00);
    for (int j = 0; j < 2; j++) begin
      r = rng[11:0];
      convData <= r;
      wr(12'h008, {3'b101, j[0], 4'h0});
      wr(12'h008, {3'b001, j[0], 4'h0});
      rd(12'h008, {25'h0, 3'b011, j[0], 4'h0});
      n = 0;
      while (convIrqReq !== 1'b1 && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      check("irq", 33'(n < 200), 33'h1);
      rd(12'h008, {25'h0, 3'b001, j[0], 4'h0});
      rd(12'h004, j ? {29'h0, r[11:8]} : {25'h0, r[11:4]});
      rd(12'h000, j ? {25'h0, r[7:0]} : {25'h0, r[3:0], 4'h0});
    end
    $display("test conversion done");
    convData <= ~r;
    wr(12'h008, 8'h90);
    wr(12'h008, 8'h10);
    repeat (30) @(posedge sys_clk);
    rd(12'h004, {29'h0, r[11:8]});
    rd(12'h000, {25'h0, r[7:0]});
    $display("test disabled hold done");
    results();
  end
endmodule
`default_nettype wire

// file: src/adcrc_consts.svh
`ifndef ADCRC_CONSTS_SVH
`define ADCRC_CONSTS_SVH
// register byte addresses on apb
`define ADCRC_OFF_RES_LO    12'h000
`define ADCRC_OFF_RES_HI    12'h004
`define ADCRC_OFF_CTRL_A    12'h008
`define ADCRC_OFF_CTRL_B    12'h00c
`define ADCRC_OFF_CTRL_C    12'h010
`define ADCRC_OFF_BANDGAP   12'h014
// field positions
`define ADCRC_A_START       7
`define ADCRC_A_BUSY        6
`define ADCRC_A_EN          5
`define ADCRC_A_JUST        4
// writable masks (unimplemented bits read zero)
`define ADCRC_MASK_A        8'hbf
`define ADCRC_MASK_B        8'hf7
`define ADCRC_MASK_C        8'h9f
`define ADCRC_MASK_BG       8'h01
`define ADCRC_RST_CTRL      8'h00
// conversion length in conversion clock periods
`define ADCRC_CONV_CLKS     16
`endif

// file: src/adcrc_pkg.sv
`default_nettype none
package adcrc_pkg;
  typedef enum logic [1:0] {
    IDLE,
    CONV,
    DONE
  } adcrc_state_t;

  typedef enum logic [2:0] {
    SRC_EXT,
    SRC_SUPPLY,
    SRC_AMPREF,
    SRC_GROUND,
    SRC_FLOAT
  } adcrc_src_t;

  // analog routing controls sent to the converter macro
  typedef struct packed {
    logic             convEnable;
    adcrc_src_t       srcKind;
    logic [1:0]       srcDivLog2;
    logic             extConnect;
    logic [3:0]       extChannel;
    logic [1:0]       refSelect;
    logic             refAmpEnable;
    logic             refAmpInput;
    logic [1:0]       refAmpGain;
    logic             bandgapEnable;
    logic             convClkTick;
    logic             sampleStart;
  } adcrc_analog_t;

  typedef struct packed {
    adcrc_state_t     state;
    logic [7:0]       ctrlA;
    logic [7:0]       ctrlB;
    logic [7:0]       ctrlC;
    logic [7:0]       bandgap;
    logic [11:0]      result;
    logic             startSeen;
    logic [6:0]       divCnt;
    logic [7:0]       convCnt;
    logic             irqFlag;
    logic [8:0]       pinOff;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    adcrc_analog_t    ana;
  } adcrc_state_s_t;
endpackage
`default_nettype wire

// file: src/adcrc_top.sv
// Design decisions made here: the APB slave port and the register addresses.
`include "adcrc_consts.svh"
`default_nettype none
// Notes on behaviour
// - a conversion starts after start bit is written high then low
// - busy flag sets when conversion starts, clears when it completes
// - enable bit powers the converter; zero switches it off
// - result registers hold their contents while converter disabled
// - justify 0: high byte d11..d4, low byte d3..d0 then zeros
// - justify 1: low byte d7..d0, high byte zeros then d11..d8
// - result bits without data read zero in both layouts
// - channel codes 0,1,5..8 select inputs; others reserved
// - channel codes 12..15 connect nothing, input floats
// - source codes 0000, 0100, 11xx use the external channel path
// - source codes 1,2,3 route supply, half, quarter
// - source codes 5,6,7 route amplified reference, half, quarter
// - source codes 10xx tie converter input to ground
// - internal source always disconnects external channel
// - conversion clock is system clock divided by two to the code
// - reference code 00 supply, 01 external pin, 1x amplified
// - analog input pin drops digital function and pull-high
// - control bits reset zero; unimplemented bits read zero
// - completion sets interrupt request flag as busy clears
// - bandgap bit 0 enables reference, resets zero, rest read zero
module adcrc_top #(
  parameter int CONV_CLKS = `ADCRC_CONV_CLKS
) (
  // clock, reset, enable
  input  wire  logic                  sys_clk,
  input  wire  logic                  rst_b,
  input  wire  logic                  clkEn,
  // apb slave
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [11:0]           paddr,
  input  wire  logic [31:0]           pwdata,
  input  wire  logic [3:0]            pstrb,
  output logic       [31:0]           prdata,
  output logic                        pready,
  output logic                        pslverr,
  // converter macro
  input  wire  logic                  convDone,
  input  wire  logic [11:0]           convData,
  input  wire  logic [8:0]            pinAnalogCfg,
  output adcrc_pkg::adcrc_analog_t    anaCtrl,
  output logic       [8:0]            pinDigitalOff,
  output logic       [8:0]            pinPullHighOff,
  output logic                        convIrqReq
);

  adcrc_pkg::adcrc_state_s_t          st_r;
  adcrc_pkg::adcrc_state_s_t          st_nxt;
  logic                    [8:0]      pinOffNxt;

  ////////////////////////////////////////////////////////////////////
  // one override flop per pin, copied straight from the mux setting
  for (genvar gp = 0; gp < 9; gp++) begin : g_pin
    assign pinOffNxt[gp] = pinAnalogCfg[gp];
  end

  ////////////////////////////////////////////////////////////////////
  // address decode shared by read and error paths
  function automatic logic [2:0] regSel(input logic [11:0] a);
    case (a)
      `ADCRC_OFF_RES_LO:  regSel = 3'h0;
      `ADCRC_OFF_RES_HI:  regSel = 3'h1;
      `ADCRC_OFF_CTRL_A:  regSel = 3'h2;
      `ADCRC_OFF_CTRL_B:  regSel = 3'h3;
      `ADCRC_OFF_CTRL_C:  regSel = 3'h4;
      `ADCRC_OFF_BANDGAP: regSel = 3'h5;
      default:            regSel = 3'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // justify picks which end of the pair carries the spare zeros
  function automatic logic [7:0] resultLow(input logic        just,
                                           input logic [11:0] res);
    if (just) begin
      resultLow = res[7:0];
    end else begin
      resultLow = {res[3:0], 4'h0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] resultHigh(input logic        just,
                                            input logic [11:0] res);
    if (just) begin
      resultHigh = {4'h0, res[11:8]};
    end else begin
      resultHigh = res[11:4];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] readMux(input logic [11:0] a,
                                         input adcrc_pkg::adcrc_state_s_t s);
    logic just;
    just = s.ctrlA[`ADCRC_A_JUST];
    case (regSel(a))
      3'h0:    readMux = resultLow(just, s.result);
      3'h1:    readMux = resultHigh(just, s.result);
      3'h2:    readMux = s.ctrlA;
      3'h3:    readMux = s.ctrlB;
      3'h4:    readMux = s.ctrlC;
      3'h5:    readMux = s.bandgap;
      default: readMux = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (regSel(a) != 3'h7);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // busy is hardware-owned, so a write keeps whatever it holds
  function automatic logic [7:0] ctrlAWrite(input logic [7:0] wv,
                                            input logic [7:0] old);
    ctrlAWrite = (wv & `ADCRC_MASK_A) |
                 {1'b0, old[`ADCRC_A_BUSY], 6'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // tick mask per divider code; a table keeps the eight ratios plain
  function automatic logic [6:0] divMask(input logic [2:0] code);
    case (code)
      3'h0:    divMask = 7'h00;
      3'h1:    divMask = 7'h01;
      3'h2:    divMask = 7'h03;
      3'h3:    divMask = 7'h07;
      3'h4:    divMask = 7'h0f;
      3'h5:    divMask = 7'h1f;
      3'h6:    divMask = 7'h3f;
      default: divMask = 7'h7f;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // source kind per input source code, external path by default
  function automatic adcrc_pkg::adcrc_src_t srcDecode(input logic [3:0] code);
    case (code)
      4'h0:    srcDecode = adcrc_pkg::SRC_EXT;
      4'h1:    srcDecode = adcrc_pkg::SRC_SUPPLY;
      4'h2:    srcDecode = adcrc_pkg::SRC_SUPPLY;
      4'h3:    srcDecode = adcrc_pkg::SRC_SUPPLY;
      4'h4:    srcDecode = adcrc_pkg::SRC_EXT;
      4'h5:    srcDecode = adcrc_pkg::SRC_AMPREF;
      4'h6:    srcDecode = adcrc_pkg::SRC_AMPREF;
      4'h7:    srcDecode = adcrc_pkg::SRC_AMPREF;
      4'h8:    srcDecode = adcrc_pkg::SRC_GROUND;
      4'h9:    srcDecode = adcrc_pkg::SRC_GROUND;
      4'ha:    srcDecode = adcrc_pkg::SRC_GROUND;
      4'hb:    srcDecode = adcrc_pkg::SRC_GROUND;
      4'hc:    srcDecode = adcrc_pkg::SRC_EXT;
      4'hd:    srcDecode = adcrc_pkg::SRC_EXT;
      4'he:    srcDecode = adcrc_pkg::SRC_EXT;
      default: srcDecode = adcrc_pkg::SRC_EXT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] srcScale(input logic [3:0] code);
    case (code)
      4'h0:    srcScale = 2'h0;
      4'h1:    srcScale = 2'h0;
      4'h2:    srcScale = 2'h1;
      4'h3:    srcScale = 2'h2;
      4'h4:    srcScale = 2'h0;
      4'h5:    srcScale = 2'h0;
      4'h6:    srcScale = 2'h1;
      4'h7:    srcScale = 2'h2;
      4'h8:    srcScale = 2'h0;
      4'h9:    srcScale = 2'h0;
      4'ha:    srcScale = 2'h0;
      4'hb:    srcScale = 2'h0;
      4'hc:    srcScale = 2'h0;
      4'hd:    srcScale = 2'h0;
      4'he:    srcScale = 2'h0;
      default: srcScale = 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  function automatic logic chanWired(input logic [3:0] code);
    case (code)
      4'h0:    chanWired = 1'b1;
      4'h1:    chanWired = 1'b1;
      4'h2:    chanWired = 1'b0;
      4'h3:    chanWired = 1'b0;
      4'h4:    chanWired = 1'b0;
      4'h5:    chanWired = 1'b1;
      4'h6:    chanWired = 1'b1;
      4'h7:    chanWired = 1'b1;
      4'h8:    chanWired = 1'b1;
      4'h9:    chanWired = 1'b0;
      4'ha:    chanWired = 1'b0;
      4'hb:    chanWired = 1'b0;
      4'hc:    chanWired = 1'b0;
      4'hd:    chanWired = 1'b0;
      4'he:    chanWired = 1'b0;
      default: chanWired = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       wrEn;
    logic       access;
    logic       busy;
    logic       enabled;
    logic       startFall;
    logic       tick;
    logic [3:0] src;
    logic [7:0] wv;
    wrEn      = 1'b0;
    access    = 1'b0;
    busy      = 1'b0;
    enabled   = 1'b0;
    startFall = 1'b0;
    tick      = 1'b0;
    src       = 4'h0;
    wv        = pwdata[7:0];
    st_nxt    = st_r;

    // apb: one wait state, registered answer in the second access cycle
    access            = psel && penable && !st_r.pready;
    wrEn              = access && pwrite && pstrb[0];
    st_nxt.pready     = access;
    st_nxt.pslverr    = access && !isMapped(paddr);
    st_nxt.prdata     = (access && !pwrite) ? {24'h0, readMux(paddr, st_r)} : 32'h0;
    st_nxt.ana.sampleStart = 1'b0;

    if (wrEn) begin
      case (paddr)
        `ADCRC_OFF_CTRL_A:  st_nxt.ctrlA   = ctrlAWrite(wv, st_r.ctrlA);
        `ADCRC_OFF_CTRL_B:  st_nxt.ctrlB   = wv & `ADCRC_MASK_B;
        `ADCRC_OFF_CTRL_C:  st_nxt.ctrlC   = wv & `ADCRC_MASK_C;
        `ADCRC_OFF_BANDGAP: st_nxt.bandgap = wv & `ADCRC_MASK_BG;
        default: ;
      endcase
    end

    busy    = st_r.ctrlA[`ADCRC_A_BUSY];
    enabled = st_r.ctrlA[`ADCRC_A_EN];

    // arm on a high start bit, fire when it is cleared again
    if (st_r.ctrlA[`ADCRC_A_START] && !busy) begin
      st_nxt.startSeen = 1'b1;
    end
    startFall = st_r.startSeen && !st_r.ctrlA[`ADCRC_A_START];
    if (startFall) begin
      st_nxt.startSeen = 1'b0;
    end

    // divider free-runs only while powered, saving toggles when off
    tick = 1'b0;
    if (enabled) begin
      st_nxt.divCnt = st_r.divCnt + 7'h01;
      tick = ((st_r.divCnt & divMask(st_r.ctrlB[2:0])) == 7'h00);
    end else begin
      st_nxt.divCnt = 7'h00;
    end
    st_nxt.ana.convClkTick = tick;

    st_nxt.irqFlag = 1'b0;
    case (st_r.state)
      adcrc_pkg::IDLE: begin
        if (startFall && enabled) begin
          st_nxt.state = adcrc_pkg::CONV;
          st_nxt.ctrlA[`ADCRC_A_BUSY] = 1'b1;
          st_nxt.convCnt = 8'h00;
          st_nxt.ana.sampleStart = 1'b1;
        end
      end
      adcrc_pkg::CONV: begin
        if (!enabled) begin
          // power-off aborts; result kept untouched
          st_nxt.state = adcrc_pkg::IDLE;
          st_nxt.ctrlA[`ADCRC_A_BUSY] = 1'b0;
        end else begin
          if (tick && st_r.convCnt != 8'hff) begin
            st_nxt.convCnt = st_r.convCnt + 8'h01;
          end
          if (convDone || (tick && st_r.convCnt >= 8'(CONV_CLKS - 1))) begin
            st_nxt.state = adcrc_pkg::DONE;
            st_nxt.result = convData;
          end
        end
      end
      adcrc_pkg::DONE: begin
        // result already stored one cycle before busy drops
        st_nxt.state = adcrc_pkg::IDLE;
        st_nxt.ctrlA[`ADCRC_A_BUSY] = 1'b0;
        st_nxt.irqFlag = 1'b1;
      end
      default: st_nxt.state = adcrc_pkg::IDLE;
    endcase

    // analog routing
    src = st_r.ctrlB[7:4];
    st_nxt.ana.convEnable    = enabled;
    st_nxt.ana.extChannel    = st_r.ctrlA[3:0];
    st_nxt.ana.srcKind       = srcDecode(src);
    st_nxt.ana.srcDivLog2    = srcScale(src);
    // internal sources leave the channel switch open
    st_nxt.ana.extConnect    = 1'b0;
    if (srcDecode(src) == adcrc_pkg::SRC_EXT) begin
      if (chanWired(st_r.ctrlA[3:0])) begin
        st_nxt.ana.extConnect = 1'b1;
      end else begin
        st_nxt.ana.srcKind = adcrc_pkg::SRC_FLOAT;
      end
    end
    st_nxt.ana.refSelect     = st_r.ctrlC[3:2];
    st_nxt.ana.refAmpEnable  = st_r.ctrlC[7];
    st_nxt.ana.refAmpInput   = st_r.ctrlC[4];
    st_nxt.ana.refAmpGain    = st_r.ctrlC[1:0];
    st_nxt.ana.bandgapEnable = st_r.bandgap[0];
    st_nxt.pinOff            = pinOffNxt;
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign prdata         = st_r.prdata;
  assign pready         = st_r.pready;
  assign pslverr        = st_r.pslverr;
  assign anaCtrl        = st_r.ana;
  assign pinDigitalOff  = st_r.pinOff;
  assign pinPullHighOff = st_r.pinOff;
  assign convIrqReq     = st_r.irqFlag;

endmodule
`default_nettype wire
